// File: inc/ccv_pkg.sv
// Purpose: Shared constants and types for the channel capture/compare value registers.
// Assumes: One 100 MHz clock, synchronous active-low reset, word-wide register port.
// Notes: Offsets are byte addresses.
// Contract
// - Value is 16 bits in bits 15:0; bits 31:16 are reserved.
// - Input mode: capture event loads the counter value into the field.
// - Input mode: the field is read-only to software.
// - Output mode: the field is compared continuously against the counter.
// - Shadow enabled: written value reaches active compare only at update events.
// - Channels 0 to 3 decode at 0x34, 0x38, 0x3C, 0x40; reset zero.
// - Four independent channels with identical behaviour.
// - Input mode captures only while the channel enable bit is set.
package ccv_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int NUM_CH = 4;
  localparam logic [ADDR_W-1:0] CH0_VALUE_OFS = 8'h34;
  localparam logic [ADDR_W-1:0] CH1_VALUE_OFS = 8'h38;
  localparam logic [ADDR_W-1:0] CH2_VALUE_OFS = 8'h3C;
  localparam logic [ADDR_W-1:0] CH3_VALUE_OFS = 8'h40;
  localparam logic [ADDR_W-1:0] CH_VALUE_STRIDE = 8'h04;
  localparam logic [VAL_W-1:0] VALUE_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Per-channel control from the rest of the timer.
  typedef struct packed {
    logic input_mode;
    logic channel_enable;
    logic shadow_enable;
    logic capture;
  } chan_ctl_s;

  // Register port request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

// File: rtl/ccv_channel.sv
`timescale 1ns/1ps
// Purpose: One capture/compare value channel with shadow and compare.
// Assumes: Mode and enables are synchronous to clk.
// Notes: Capture takes priority over a software write in the same cycle.
module ccv_channel #(
  parameter int VW = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Timer side
  input wire ccv_pkg::chan_ctl_s ctl,
  input wire logic update,
  input wire logic [VW-1:0] counter,
  // Software side
  input wire logic wr,
  input wire logic [VW-1:0] wdata,
  // Results
  output logic [VW-1:0] value_r,
  output logic [VW-1:0] active_r,
  output logic match_r
);
  import ccv_pkg::*;

  logic [VW-1:0] value_nxt;
  logic [VW-1:0] active_nxt;
  logic match_nxt;

  always_comb begin
    value_nxt = value_r;
    active_nxt = active_r;
    if (ctl.input_mode) begin
      if (ctl.capture && ctl.channel_enable) begin
        value_nxt = counter;
      end
      // Writes are dropped so a capture is never overwritten.
    end else begin
      if (wr) begin
        value_nxt = wdata;
      end
      if (!ctl.shadow_enable) begin
        active_nxt = value_nxt;
      end else if (update) begin
        active_nxt = value_r;
      end
    end
    match_nxt = !ctl.input_mode && (counter == active_nxt);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      value_r <= VALUE_RST;
      active_r <= VALUE_RST;
      match_r <= 1'b0;
    end else begin
      value_r <= value_nxt;
      active_r <= active_nxt;
      match_r <= match_nxt;
    end
  end

  a_capture_loads: assert property (@(posedge clk) disable iff (!rst_b)
    ctl.input_mode && ctl.capture && ctl.channel_enable |=> value_r == $past(counter))
    else $error("capture did not load counter");
  a_input_readonly: assert property (@(posedge clk) disable iff (!rst_b)
    ctl.input_mode && !(ctl.capture && ctl.channel_enable) |=> $stable(value_r))
    else $error("input-mode value changed without capture");
  a_capture_gated: assert property (@(posedge clk) disable iff (!rst_b)
    ctl.input_mode && !ctl.channel_enable |=> value_r == $past(value_r))
    else $error("capture while channel disabled");
  a_shadow_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !ctl.input_mode && ctl.shadow_enable && !update |=> $stable(active_r))
    else $error("shadowed compare changed without update");
  a_shadow_load: assert property (@(posedge clk) disable iff (!rst_b)
    !ctl.input_mode && ctl.shadow_enable && update |=> active_r == $past(value_r))
    else $error("update did not load compare");
  a_direct_write: assert property (@(posedge clk) disable iff (!rst_b)
    !ctl.input_mode && !ctl.shadow_enable && wr |=> active_r == $past(wdata))
    else $error("unshadowed write not immediate");
  a_compare_match: assert property (@(posedge clk) disable iff (!rst_b)
    match_r |-> !$past(ctl.input_mode) && $past(counter) == active_r)
    else $error("match without equal compare");
  c_capture: cover property (@(posedge clk) ctl.input_mode && ctl.capture && ctl.channel_enable);
  c_update: cover property (@(posedge clk) ctl.shadow_enable && update && !ctl.input_mode);
  c_match: cover property (@(posedge clk) match_r);
endmodule

// File: rtl/ccv_regs.sv
`timescale 1ns/1ps
// Purpose: Four channel capture/compare value registers on a word register port.
// Assumes: Word-only accesses; strobes are one cycle and never both at once.
// Notes: Unmapped reads return zero; unmapped writes are ignored.
module ccv_regs #(
  parameter int CH = ccv_pkg::NUM_CH,
  parameter int VW = ccv_pkg::VAL_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire ccv_pkg::reg_req_s req,
  output logic [ccv_pkg::DATA_W-1:0] rdata_r,
  // Timer side
  input wire logic [VW-1:0] counter,
  input wire logic update,
  input wire ccv_pkg::chan_ctl_s [CH-1:0] ctl,
  // Compare results
  output logic [CH-1:0] match_r,
  output logic [CH*VW-1:0] active_r
);
  import ccv_pkg::*;

  logic [CH-1:0][VW-1:0] value;
  logic [CH-1:0][VW-1:0] active;
  logic [CH-1:0] match;
  logic [CH-1:0] wr_sel;
  logic [DATA_W-1:0] rdata_nxt;

  // Returns the channel hit by an address, or CH when unmapped.
  function automatic int chan_of(input logic [ADDR_W-1:0] a);
    chan_of = CH;
    for (int i = 0; i < CH; i++) begin
      if (a == CH0_VALUE_OFS + ADDR_W'(i) * CH_VALUE_STRIDE) begin
        chan_of = i;
      end
    end
  endfunction

  always_comb begin
    wr_sel = '0;
    rdata_nxt = RDATA_RST;
    for (int i = 0; i < CH; i++) begin
      // Only the low half is stored; upper write bits are expected zero.
      wr_sel[i] = req.wr && (chan_of(req.addr) == i);
      if (req.rd && chan_of(req.addr) == i) begin
        rdata_nxt = {{(DATA_W-VW){1'b0}}, value[i]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_r <= RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Each channel owns its storage so one cannot disturb another.
  for (genvar g = 0; g < CH; g++) begin : g_ch
    ccv_channel #(.VW(VW)) u_ch (
      .clk(clk),
      .rst_b(rst_b),
      .ctl(ctl[g]),
      .update(update),
      .counter(counter),
      .wr(wr_sel[g]),
      .wdata(req.wdata[VW-1:0]),
      .value_r(value[g]),
      .active_r(active[g]),
      .match_r(match[g])
    );
  end

  always_comb begin
    match_r = match;
    active_r = active;
  end

  a_read_data: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == CH0_VALUE_OFS |=> rdata_r == {16'h0000, $past(value[0])})
    else $error("channel 0 read data wrong");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_b)
    rdata_r[DATA_W-1:VW] == '0)
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && chan_of(req.addr) == CH |=> rdata_r == RDATA_RST)
    else $error("unmapped read not zero");

  a_ch1_read_data: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == CH1_VALUE_OFS
    |=> rdata_r == {16'h0000, $past(value[1])})
    else $error("channel 1 read data wrong");
  a_ch2_read_data: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == CH2_VALUE_OFS
    |=> rdata_r == {16'h0000, $past(value[2])})
    else $error("channel 2 read data wrong");
  a_ch3_read_data: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == CH3_VALUE_OFS
    |=> rdata_r == {16'h0000, $past(value[3])})
    else $error("channel 3 read data wrong");

  a_read_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !req.rd
    |=> rdata_r == RDATA_RST)
    else $error("read data not zero outside a read");

  a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && chan_of(req.addr) == CH
    |-> wr_sel == '0)
    else $error("unmapped write reached a channel");

  // Output-mode writes land in the addressed channel only.
  a_ch0_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH0_VALUE_OFS && !ctl[0].input_mode
    |=> value[0] == $past(req.wdata[VW-1:0]))
    else $error("channel 0 write not stored");
  a_ch1_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH1_VALUE_OFS && !ctl[1].input_mode
    |=> value[1] == $past(req.wdata[VW-1:0]))
    else $error("channel 1 write not stored");
  a_ch2_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH2_VALUE_OFS && !ctl[2].input_mode
    |=> value[2] == $past(req.wdata[VW-1:0]))
    else $error("channel 2 write not stored");
  a_ch3_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH3_VALUE_OFS && !ctl[3].input_mode
    |=> value[3] == $past(req.wdata[VW-1:0]))
    else $error("channel 3 write not stored");

  // Input-mode writes are dropped; only a capture may move the field.
  a_ch0_write_refused: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH0_VALUE_OFS && ctl[0].input_mode
    && !(ctl[0].capture && ctl[0].channel_enable)
    |=> $stable(value[0]))
    else $error("channel 0 input-mode write altered the value");
  a_ch1_write_refused: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH1_VALUE_OFS && ctl[1].input_mode
    && !(ctl[1].capture && ctl[1].channel_enable)
    |=> $stable(value[1]))
    else $error("channel 1 input-mode write altered the value");
  a_ch2_write_refused: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH2_VALUE_OFS && ctl[2].input_mode
    && !(ctl[2].capture && ctl[2].channel_enable)
    |=> $stable(value[2]))
    else $error("channel 2 input-mode write altered the value");
  a_ch3_write_refused: assert property (@(posedge clk) disable iff (!rst_b)
    req.wr && req.addr == CH3_VALUE_OFS && ctl[3].input_mode
    && !(ctl[3].capture && ctl[3].channel_enable)
    |=> $stable(value[3]))
    else $error("channel 3 input-mode write altered the value");

  // Checked per channel so a decode slip into a neighbour is caught.
  a_ch0_write_isolated: assert property (@(posedge clk) disable iff (!rst_b)
    !ctl[0].input_mode && !(req.wr && req.addr == CH0_VALUE_OFS)
    |=> $stable(value[0]))
    else $error("channel 0 value changed without its own write");
  a_ch1_write_isolated: assert property (@(posedge clk) disable iff (!rst_b)
    !ctl[1].input_mode && !(req.wr && req.addr == CH1_VALUE_OFS)
    |=> $stable(value[1]))
    else $error("channel 1 value changed without its own write");
  a_ch2_write_isolated: assert property (@(posedge clk) disable iff (!rst_b)
    !ctl[2].input_mode && !(req.wr && req.addr == CH2_VALUE_OFS)
    |=> $stable(value[2]))
    else $error("channel 2 value changed without its own write");
  a_ch3_write_isolated: assert property (@(posedge clk) disable iff (!rst_b)
    !ctl[3].input_mode && !(req.wr && req.addr == CH3_VALUE_OFS)
    |=> $stable(value[3]))
    else $error("channel 3 value changed without its own write");

  a_ch0_no_match: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[0].input_mode
    |=> !match_r[0])
    else $error("channel 0 matched in input mode");
  a_ch1_no_match: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[1].input_mode
    |=> !match_r[1])
    else $error("channel 1 matched in input mode");
  a_ch2_no_match: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[2].input_mode
    |=> !match_r[2])
    else $error("channel 2 matched in input mode");
  a_ch3_no_match: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[3].input_mode
    |=> !match_r[3])
    else $error("channel 3 matched in input mode");

  a_ch0_active_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[0].input_mode
    |=> $stable(active[0]))
    else $error("channel 0 compare value moved in input mode");
  a_ch1_active_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[1].input_mode
    |=> $stable(active[1]))
    else $error("channel 1 compare value moved in input mode");
  a_ch2_active_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[2].input_mode
    |=> $stable(active[2]))
    else $error("channel 2 compare value moved in input mode");
  a_ch3_active_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[3].input_mode
    |=> $stable(active[3]))
    else $error("channel 3 compare value moved in input mode");

  // A disabled input channel must ignore capture strobes from the timer.
  a_ch0_disabled_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[0].input_mode && !ctl[0].channel_enable
    |=> $stable(value[0]))
    else $error("channel 0 captured while disabled");
  a_ch1_disabled_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[1].input_mode && !ctl[1].channel_enable
    |=> $stable(value[1]))
    else $error("channel 1 captured while disabled");
  a_ch2_disabled_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[2].input_mode && !ctl[2].channel_enable
    |=> $stable(value[2]))
    else $error("channel 2 captured while disabled");
  a_ch3_disabled_hold: assert property (@(posedge clk) disable iff (!rst_b)
    ctl[3].input_mode && !ctl[3].channel_enable
    |=> $stable(value[3]))
    else $error("channel 3 captured while disabled");

  c_input_write: cover property (@(posedge clk) wr_sel[0] && ctl[0].input_mode);
  c_read_ch3: cover property (@(posedge clk) req.rd && req.addr == CH3_VALUE_OFS);
endmodule

// File: test/ccv_regs_bench.sv
`timescale 1ns/1ps
// Purpose: Random self-checking bench for the channel value registers.
// Assumes: Word accesses only, with the reserved upper write bits kept at zero.
// Notes: Modes stay fixed between resets, since a mode change leaves active values open.
module ccv_regs_bench;
  import ccv_pkg::*;
  logic clk;
  logic rst_b;
  reg_req_s req;
  logic [DATA_W-1:0] rdata_r;
  logic [VAL_W-1:0] counter;
  logic update;
  chan_ctl_s [NUM_CH-1:0] ctl;
  logic [NUM_CH-1:0] match_r;
  logic [NUM_CH*VAL_W-1:0] active_r;
  int err_total = 0;
  int n_compared = 0;
  integer seed = 32'h2158;
  logic [VAL_W-1:0] val [NUM_CH];
  logic [VAL_W-1:0] act [NUM_CH];
  logic [VAL_W-1:0] old;
  logic [VAL_W-1:0] msk;
  logic [DATA_W-1:0] exp_rd;
  logic [NUM_CH-1:0] exp_m;
  int a;
  int ch;
  int k;
  ccv_regs ccv_regs_i (.clk(clk), .rst_b(rst_b), .req(req), .rdata_r(rdata_r),
    .counter(counter), .update(update), .ctl(ctl), .match_r(match_r), .active_r(active_r));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #50000;
    err_total++;
    finish_test();
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    counter = '0;
    update = 1'b0;
    ctl = '0;
    for (int ph = 0; ph < 4; ph++) begin
      @(posedge clk);
      rst_b <= 1'b0;
      req <= '0;
      update <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        // Modes rotate by phase so every channel meets every mode and shadow setting.
        ctl[i] <= {1'(ph + i), 1'b0, 1'((ph + i) >> 1), 1'b0};
        val[i] = '0;
        act[i] = '0;
      end
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      repeat (300) begin
        @(posedge clk);
        a = int'(req.addr);
        ch = (a >= int'(CH0_VALUE_OFS) && a <= int'(CH3_VALUE_OFS)) ?
          (a - int'(CH0_VALUE_OFS)) / int'(CH_VALUE_STRIDE) : -1;
        exp_rd = '0;
        for (int i = 0; i < NUM_CH; i++) begin
          old = val[i];
          if (req.rd && ch == i) exp_rd = {16'h0000, old};
          if (ctl[i].input_mode) begin
            if (ctl[i].channel_enable && ctl[i].capture) val[i] = counter;
          end else begin
            if (req.wr && ch == i) val[i] = req.wdata[VAL_W-1:0];
            if (!ctl[i].shadow_enable) act[i] = val[i];
            else if (update) act[i] = old;
          end
          exp_m[i] = !ctl[i].input_mode && act[i] == counter;
        end
        // A narrow value range makes compare hits common; wide values still come half the time.
        k = {$random(seed)} % 4;
        msk = ($random(seed) & 1) ? 16'hFFFF : 16'h0007;
        req.rd <= (k == 1);
        req.wr <= (k == 2);
        req.addr <= 8'h30 + 8'(4 * ({$random(seed)} % 6));
        req.wdata <= {16'h0000, 16'($random(seed)) & msk};
        counter <= 16'($random(seed)) & msk;
        update <= ({$random(seed)} % 4) == 0;
        for (int i = 0; i < NUM_CH; i++) begin
          ctl[i].capture <= 1'($random(seed));
          ctl[i].channel_enable <= 1'($random(seed));
        end
        #1;
        chk("rdata", rdata_r, exp_rd);
        chk("match", match_r, exp_m);
        for (int i = 0; i < NUM_CH; i++) begin
          if (!ctl[i].input_mode) chk("active", active_r[i*VAL_W +: VAL_W], act[i]);
        end
      end
    end
    finish_test();
  end
endmodule
